/* logic/icc_pkg.sv */
// shared constants for the two-wire interrupt and start/stop control block
`default_nettype none
package icc_pkg;
  // ==========================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_EVT = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [7:0] ADDR_FSW = 8'h10;
  localparam logic [7:0] ADDR_SADR = 8'h14;
  // ==========================================
  // control register fields
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_FORMAT = 1;
  localparam int CTRL_ACK_CHECK = 2;
  localparam int CTRL_MODE_LO = 3;
  // ==========================================
  // status register fields
  localparam int ST_ISSUE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_IRQ = 2;
  localparam int ST_ACK_VAL = 3;
  localparam int ST_STOP = 4;
  localparam int ST_ERR_STOP = 5;
  localparam int ST_ADDR_MATCH = 6;
  localparam int ST_ADDR2_MATCH = 7;
  localparam int ST_GEN_CALL = 8;
  localparam int ST_TX_EMPTY = 9;
  localparam int ST_RX_FULL = 10;
  // ==========================================
  // event register fields
  localparam int EV_IRQ = 0;
  localparam int EV_START = 1;
  localparam int EV_STOP = 2;
  localparam int EV_W = 3;
  // ==========================================
  // address fields and reset values
  localparam int SADR_SECOND_LO = 8;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [6:0] SADR_FIRST_RST = 7'h00;
  localparam logic [6:0] SADR_SECOND_RST = 7'h00;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {ICC_MODE_TWI, ICC_MODE_CLKSER, ICC_MODE_NOFMT} icc_mode_t;
endpackage
`default_nettype wire

/* logic/icc_irq_ctrl.sv */
// two-wire controller interrupt flag and start/stop issue logic with apb registers
// Function
// [R1] slave address match sets flag, then each transfer
// [R2] general call with format zero sets flag similarly
// [R3] ack one with checking enabled sets flag
// [R4] stop detection sets flag with stop flags
// [R5] clocked modes: transfer end sets flag
// [R6] serial format: start condition sets flag
// [R7] clocked modes: format switch bit sets flag
// [R8] clocked modes: other empty/full sets flag
// [R9] busy one, issue zero requests start
// [R10] same write gives repeated start
// [R11] busy zero, issue zero requests stop
// [R12] issue bit reads one, one ignored
// [R13] flag clears by write zero after read
// [R14] issue writes act only in master mode
`timescale 1ns/1ns
`default_nettype none
module icc_irq_ctrl
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic addr_rcvd,
  input wire logic [6:0] addr_byte,
  input wire logic xfer_done,
  input wire logic xfer_dir_tx,
  input wire logic other_flag_set,
  input wire logic ack_rcvd,
  input wire logic ack_val,
  input wire logic frame_busy,
  input wire logic dtc_access,
  output logic start_req,
  output logic stop_req,
  output logic interrupt_request_flag,
  output logic irq
);
  // ==========================================
  // register decode
  wire acc = psel && penable && ce;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_ctrl = paddr == icc_pkg::ADDR_CTRL;
  wire hit_stat = paddr == icc_pkg::ADDR_STAT;
  wire hit_evt = paddr == icc_pkg::ADDR_EVT;
  wire hit_mask = paddr == icc_pkg::ADDR_MASK;
  wire hit_fsw = paddr == icc_pkg::ADDR_FSW;
  wire hit_sadr = paddr == icc_pkg::ADDR_SADR;
  wire mapped = hit_ctrl || hit_stat || hit_evt || hit_mask || hit_fsw || hit_sadr;

  logic master_r;
  logic format_select_r;
  logic ack_check_enable_r;
  icc_pkg::icc_mode_t mode_r;
  logic bus_busy_flag_r;
  logic irq_flag_r;
  logic flag_seen_r;
  logic ack_bit_value_r;
  logic stop_r;
  logic error_stop_r;
  logic addr_match_flag_r;
  logic second_addr_match_flag_r;
  logic general_call_flag_r;
  logic tx_empty_flag_r;
  logic rx_full_flag_r;
  logic slave_sess_r;
  logic format_switch_bit_r;
  logic [6:0] own_slave_addr_first_r;
  logic [6:0] own_slave_addr_second_r;
  logic [icc_pkg::EV_W-1:0] evt_r;
  logic [icc_pkg::EV_W-1:0] mask_r;
  logic start_req_r;
  logic stop_req_r;
  logic [31:0] prdata_r;

  // ==========================================
  // link pin synchronisers and condition detect
  logic [icc_pkg::SYNC_STAGES-1:0] scl_sync_r;
  logic [icc_pkg::SYNC_STAGES-1:0] sda_sync_r;
  logic sda_prev_r;
  wire scl_s = scl_sync_r[icc_pkg::SYNC_STAGES-1];
  wire sda_s = sda_sync_r[icc_pkg::SYNC_STAGES-1];
  wire start_det = scl_s && sda_prev_r && !sda_s;
  wire stop_det = scl_s && !sda_prev_r && sda_s;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_sync_r <= '1;
      sda_sync_r <= '1;
      sda_prev_r <= 1'b1;
    end
    else if (ce)
    begin
      scl_sync_r <= {scl_sync_r[icc_pkg::SYNC_STAGES-2:0], scl_in};
      sda_sync_r <= {sda_sync_r[icc_pkg::SYNC_STAGES-2:0], sda_in};
      sda_prev_r <= sda_s;
    end
  end

  // ==========================================
  // mode qualifiers and flag set terms
  wire twi_mode = mode_r == icc_pkg::ICC_MODE_TWI;
  wire slave_twi = twi_mode && !master_r;
  wire clk_mode = !twi_mode;
  wire match_first = addr_byte == own_slave_addr_first_r;
  wire match_second = addr_byte == own_slave_addr_second_r;
  wire match_gc = addr_byte == icc_pkg::GENERAL_CALL_ADDR && !format_select_r;
  wire addr_hit = slave_twi && addr_rcvd && (match_first || match_second);
  wire gc_hit = slave_twi && addr_rcvd && match_gc;
  wire ack_hit = slave_twi && ack_check_enable_r && ack_rcvd && ack_val;
  wire stop_hit = slave_twi && stop_det;
  wire sess_end = start_det || stop_det;
  wire sess_xfer = slave_twi && slave_sess_r && xfer_done && !sess_end;
  wire clk_xfer = clk_mode && (xfer_done || other_flag_set);
  wire fmt_start = clk_mode && format_select_r && start_det;
  wire fsw_rise = clk_mode && wr && hit_fsw && pwdata[0] && !format_switch_bit_r;
  wire flag_set_any = xfer_done || other_flag_set;

  wire flag_set = addr_hit // R1
    || gc_hit // R2
    || ack_hit // R3
    || stop_hit // R4
    || sess_xfer // R1
    || clk_xfer // R5 R8
    || fmt_start // R6
    || fsw_rise; // R7

  // write zero after reading one, or a transfer controller data access
  wire flag_cpu_clr = wr && hit_stat && !pwdata[icc_pkg::ST_IRQ] && flag_seen_r; // R13
  wire flag_clr = flag_cpu_clr || dtc_access; // R13

  // issue bit writes, master mode only
  wire issue_wr = wr && hit_stat && !pwdata[icc_pkg::ST_ISSUE] && master_r; // R14
  wire issue_start = issue_wr && pwdata[icc_pkg::ST_BUSY]; // R9 R10
  wire issue_stop = issue_wr && !pwdata[icc_pkg::ST_BUSY]; // R11

  // ==========================================
  // control registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      master_r <= 1'b0;
      format_select_r <= 1'b0;
      ack_check_enable_r <= 1'b0;
      mode_r <= icc_pkg::ICC_MODE_TWI;
      own_slave_addr_first_r <= icc_pkg::SADR_FIRST_RST;
      own_slave_addr_second_r <= icc_pkg::SADR_SECOND_RST;
      mask_r <= '0;
      format_switch_bit_r <= 1'b0;
    end
    else if (ce)
    begin
      if (wr && hit_ctrl)
      begin
        master_r <= pwdata[icc_pkg::CTRL_MASTER];
        format_select_r <= pwdata[icc_pkg::CTRL_FORMAT];
        ack_check_enable_r <= pwdata[icc_pkg::CTRL_ACK_CHECK];
        mode_r <= icc_pkg::icc_mode_t'(pwdata[icc_pkg::CTRL_MODE_LO +: 2]);
      end
      if (wr && hit_sadr)
      begin
        own_slave_addr_first_r <= pwdata[6:0];
        own_slave_addr_second_r <= pwdata[icc_pkg::SADR_SECOND_LO +: 7];
      end
      if (wr && hit_mask)
        mask_r <= pwdata[icc_pkg::EV_W-1:0];
      if (wr && hit_fsw)
        format_switch_bit_r <= pwdata[0]; // R7
    end
  end

  // ==========================================
  // interrupt flag and slave status flags
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_flag_r <= 1'b0;
      flag_seen_r <= 1'b0;
      ack_bit_value_r <= 1'b0;
      stop_r <= 1'b0;
      error_stop_r <= 1'b0;
      addr_match_flag_r <= 1'b0;
      second_addr_match_flag_r <= 1'b0;
      general_call_flag_r <= 1'b0;
      slave_sess_r <= 1'b0;
    end
    else if (ce)
    begin
      // set wins over clear
      if (flag_set)
        irq_flag_r <= 1'b1;
      else if (flag_clr)
        irq_flag_r <= 1'b0; // R13
      // seen only if the word handed to software held a one
      if (flag_clr || flag_set)
        flag_seen_r <= 1'b0;
      else if (rd && hit_stat && prdata_r[icc_pkg::ST_IRQ])
        flag_seen_r <= 1'b1; // R13
      if (ack_hit)
        ack_bit_value_r <= 1'b1; // R3
      else if (ack_rcvd && slave_twi)
        ack_bit_value_r <= ack_val;
      if (stop_hit && !frame_busy)
        stop_r <= 1'b1; // R4
      else if (flag_clr)
        stop_r <= 1'b0;
      if (stop_hit && frame_busy)
        error_stop_r <= 1'b1; // R4
      else if (flag_clr)
        error_stop_r <= 1'b0;
      if (addr_hit || gc_hit)
      begin
        addr_match_flag_r <= match_first || match_second; // R1
        second_addr_match_flag_r <= match_second && !match_first; // R1
        general_call_flag_r <= match_gc; // R2
      end
      else if (sess_end)
      begin
        addr_match_flag_r <= 1'b0;
        second_addr_match_flag_r <= 1'b0;
        general_call_flag_r <= 1'b0;
      end
      // transfers count until repeated start or stop
      if (addr_hit || gc_hit)
        slave_sess_r <= 1'b1; // R1 R2
      else if (sess_end || !slave_twi)
        slave_sess_r <= 1'b0; // R1 R2
    end
  end

  // ==========================================
  // data flags, cleared by transfer controller access
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_empty_flag_r <= 1'b0;
      rx_full_flag_r <= 1'b0;
    end
    else if (ce)
    begin
      if (flag_set_any && xfer_dir_tx)
        tx_empty_flag_r <= 1'b1; // R5 R8
      else if (dtc_access)
        tx_empty_flag_r <= 1'b0;
      if (flag_set_any && !xfer_dir_tx)
        rx_full_flag_r <= 1'b1; // R5 R8
      else if (dtc_access)
        rx_full_flag_r <= 1'b0;
    end
  end

  // ==========================================
  // bus busy and start/stop requests
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_busy_flag_r <= 1'b0;
      start_req_r <= 1'b0;
      stop_req_r <= 1'b0;
    end
    else if (ce)
    begin
      start_req_r <= issue_start; // R9 R10
      stop_req_r <= issue_stop; // R11
      if (issue_start)
        bus_busy_flag_r <= 1'b1; // R9
      else if (issue_stop)
        bus_busy_flag_r <= 1'b0; // R11
    end
  end

  // ==========================================
  // sticky events, cleared by reading them
  wire [icc_pkg::EV_W-1:0] evt_in = {stop_det, start_det, flag_set};
  wire evt_rd = rd && hit_evt;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      evt_r <= '0;
    else if (ce)
      evt_r <= (evt_rd ? evt_r & ~prdata_r[icc_pkg::EV_W-1:0] : evt_r) | evt_in; // only read bits
  end

  // ==========================================
  // read mux
  wire [31:0] stat_word = {21'h000000, rx_full_flag_r, tx_empty_flag_r,
    general_call_flag_r, second_addr_match_flag_r, addr_match_flag_r,
    error_stop_r, stop_r, ack_bit_value_r, irq_flag_r, bus_busy_flag_r,
    1'b1}; // R12
  wire [31:0] ctrl_word = {27'h0000000, mode_r, ack_check_enable_r, format_select_r,
    master_r};
  wire [31:0] sadr_word = {17'h00000, own_slave_addr_second_r, 1'b0,
    own_slave_addr_first_r};
  wire [31:0] rd_word = hit_ctrl ? ctrl_word :
    hit_stat ? stat_word :
    hit_evt ? {29'h00000000, evt_r} :
    hit_mask ? {29'h00000000, mask_r} :
    hit_fsw ? {31'h00000000, format_switch_bit_r} :
    hit_sadr ? sadr_word : 32'h00000000;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      prdata_r <= 32'h00000000;
    else if (ce && psel && !penable && !pwrite)
      prdata_r <= rd_word;
  end

  // ==========================================
  // outputs
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign start_req = start_req_r;
  assign stop_req = stop_req_r;
  assign interrupt_request_flag = irq_flag_r;
  assign irq = |(evt_r & mask_r);
endmodule
`default_nettype wire

/* dv/icc_bus_model.sv */
// two-wire bus partner making start and stop conditions
`timescale 1ns/1ns
`default_nettype none
module icc_bus_model
(
  output logic scl,
  output logic sda
);
  // lines idle high through pull-ups
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // stop low gives a start, high gives a stop; 1600 ns clock
  task automatic cond(input logic stop);
    // offset keeps pin changes off the system clock edge
    #20 scl = 1'b0;
    #400 sda = ~stop;
    #400 scl = 1'b1;
    #400 sda = stop;
    #400 scl = stop;
  endtask
endmodule
`default_nettype wire

/* dv/icc_irq_ctrl_checker.sv */
// assertions on the interrupt flag and start/stop issue ports
`timescale 1ns/1ns
`default_nettype none
module icc_irq_ctrl_checker
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic addr_rcvd,
  input wire logic [6:0] addr_byte,
  input wire logic xfer_done,
  input wire logic other_flag_set,
  input wire logic ack_rcvd,
  input wire logic ack_val,
  input wire logic dtc_access,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic interrupt_request_flag
);
  logic [4:0] ctrl_r;
  logic [14:0] sadr_r;
  wire wr = psel && penable && pwrite;
  wire wr_stat = wr && paddr == icc_pkg::ADDR_STAT;
  wire iss = wr_stat && ctrl_r[0] && !pwdata[0];
  wire slv = !ctrl_r[0] && ctrl_r[4:3] == 2'h0;
  wire own = addr_byte == sadr_r[6:0] || addr_byte == sadr_r[14:8];
  wire irf = interrupt_request_flag;
  // shadow of control and own-address registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= 5'h00;
      sadr_r <= 15'h0000;
    end
    else if (wr && paddr == icc_pkg::ADDR_CTRL)
      ctrl_r <= pwdata[4:0];
    else if (wr && paddr == icc_pkg::ADDR_SADR)
      sadr_r <= pwdata[14:0];
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_issue;
    iss;
  endsequence
  property p_start;
    s_issue ##0 pwdata[1] |=> start_req && !stop_req;
  endproperty
  a_start: assert property (p_start) else $error("start missing");
  property p_stop;
    s_issue ##0 !pwdata[1] |=> stop_req && !start_req;
  endproperty
  a_stop: assert property (p_stop) else $error("stop missing");
  property p_quiet;
    start_req || stop_req |-> $past(iss);
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray condition");
  property p_addr;
    addr_rcvd && slv && own |=> irf;
  endproperty
  a_addr: assert property (p_addr) else $error("no flag on match");
  property p_gcall;
    addr_rcvd && slv && !ctrl_r[1] && addr_byte == icc_pkg::GENERAL_CALL_ADDR |=> irf;
  endproperty
  a_gcall: assert property (p_gcall) else $error("no flag on call");
  property p_ack;
    ack_rcvd && ack_val && slv && ctrl_r[2] |=> irf;
  endproperty
  a_ack: assert property (p_ack) else $error("no flag on ack");
  property p_clk;
    (xfer_done || other_flag_set) && ctrl_r[4:3] != 2'h0 |=> irf;
  endproperty
  a_clk: assert property (p_clk) else $error("no flag on transfer");
  property p_hold;
    irf && !dtc_access && !(wr_stat && !pwdata[icc_pkg::ST_IRQ]) |=> irf;
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");
endmodule
`default_nettype wire

/* dv/icc_irq_ctrl_test.sv */
// self-checking bench for the interrupt flag and start/stop issue block
`timescale 1ns/1ns
`default_nettype none
module icc_irq_ctrl_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic frame_busy = 1'b0;
  logic psel, penable, pwrite, perr, pready, pslverr, scl, sda, start_req, stop_req, irf, irq;
  logic addr_rcvd, xfer_done, xfer_dir_tx, other_flag_set, ack_rcvd, ack_val, dtc_access;
  logic [6:0] addr_byte;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int fails = 0;
  int n_tests = 0;
  int n_start = 0;
  int n_stop = 0;
  int cyc = 0;
  always #50 sys_clk = ~sys_clk;
  icc_bus_model bm (.scl(scl), .sda(sda));
  icc_irq_ctrl DUT
  (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl), .sda_in(sda), .addr_rcvd(addr_rcvd), .addr_byte(addr_byte),
    .xfer_done(xfer_done), .xfer_dir_tx(xfer_dir_tx), .other_flag_set(other_flag_set),
    .ack_rcvd(ack_rcvd), .ack_val(ack_val), .frame_busy(frame_busy), .dtc_access(dtc_access),
    .start_req(start_req), .stop_req(stop_req), .interrupt_request_flag(irf), .irq(irq)
  );
  always @(negedge sys_clk)
  begin
    n_start += int'(start_req === 1'b1);
    n_stop += int'(stop_req === 1'b1);
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  // one-cycle pulse on an event input
  task automatic ev(input int k);
    case (k)
      0: addr_rcvd <= 1'b1;
      1: xfer_done <= 1'b1;
      2: other_flag_set <= 1'b1;
      3: ack_rcvd <= 1'b1;
      default: dtc_access <= 1'b1;
    endcase
    @(posedge sys_clk);
    {addr_rcvd, xfer_done, other_flag_set, ack_rcvd, dtc_access} <= 5'h00;
    @(posedge sys_clk);
  endtask
  task automatic bus(input logic stop);
    bm.cond(stop);
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic t_slave;
    apb(icc_pkg::ADDR_SADR, 1, 32'h152A);
    apb(icc_pkg::ADDR_MASK, 1, 32'h1);
    addr_byte <= 7'h15;
    ev(0);
    chk(irf, 1'b1);
    chk(irq, 1'b1);
    apb(icc_pkg::ADDR_MASK, 1, 32'h0);
    chk(irq, 1'b0);
    apb(icc_pkg::ADDR_STAT, 1, 32'h0);
    chk(irf, 1'b1);
    apb(icc_pkg::ADDR_STAT, 0, 32'h0);
    chk(q[7:6], 2'h3);
    apb(icc_pkg::ADDR_STAT, 1, 32'h0);
    chk(irf, 1'b0);
    apb(icc_pkg::ADDR_EVT, 0, 32'h0);
    apb(icc_pkg::ADDR_MASK, 1, 32'h1);
    chk(irq, 1'b0);
    ev(1);
    chk(irf, 1'b1);
    ev(4);
    chk(irf, 1'b0);
    bus(1);
    chk(irf, 1'b1);
    apb(icc_pkg::ADDR_STAT, 0, 32'h0);
    chk(q[4], 1'b1);
    ev(4);
    ev(1);
    chk(irf, 1'b0);
    addr_byte <= icc_pkg::GENERAL_CALL_ADDR;
    ev(0);
    chk(irf, 1'b1);
    ev(4);
    apb(icc_pkg::ADDR_CTRL, 1, 32'h6);
    ev(0);
    chk(irf, 1'b0);
    ack_val <= 1'b1;
    ev(3);
    chk(irf, 1'b1);
    apb(icc_pkg::ADDR_STAT, 0, 32'h0);
    chk(q[3], 1'b1);
    ev(4);
    apb(icc_pkg::ADDR_EVT, 0, 32'h0);
    frame_busy <= 1'b1;
    bus(1);
    chk(irf, 1'b1);
    apb(icc_pkg::ADDR_STAT, 0, 32'h0);
    chk(q[5:4], 2'h2);
    apb(icc_pkg::ADDR_EVT, 0, 32'h0);
    chk(q[2], 1'b1);
    frame_busy <= 1'b0;
    ev(4);
    $display("end slave");
  endtask
  task automatic t_clk;
    for (int m = 1; m < 3; m++)
    begin
      apb(icc_pkg::ADDR_CTRL, 1, 32'(m) << 3);
      xfer_dir_tx <= (m == 1);
      ev(1);
      chk(irf, 1'b1);
      apb(icc_pkg::ADDR_STAT, 0, 32'h0);
      chk(q[8 + m], 1'b1);
      ev(4);
      ev(2);
      chk(irf, 1'b1);
      ev(4);
      apb(icc_pkg::ADDR_FSW, 1, 32'h0);
      apb(icc_pkg::ADDR_FSW, 1, 32'h1);
      chk(irf, 1'b1);
      ev(4);
      apb(icc_pkg::ADDR_CTRL, 1, (32'(m) << 3) | 32'h2);
      bus(0);
      chk(irf, 1'b1);
      bus(1);
      ev(4);
    end
    $display("end clocked");
  endtask
  task automatic t_master;
    apb(icc_pkg::ADDR_CTRL, 1, 32'h1);
    apb(icc_pkg::ADDR_STAT, 1, 32'h2);
    chk(n_start, 1);
    apb(icc_pkg::ADDR_STAT, 0, 32'h0);
    chk(q[1:0], 2'h3);
    apb(icc_pkg::ADDR_STAT, 1, 32'h2);
    chk(n_start, 2);
    apb(icc_pkg::ADDR_STAT, 1, 32'h3);
    chk(n_start + n_stop, 2);
    apb(icc_pkg::ADDR_STAT, 1, 32'h0);
    chk(n_stop, 1);
    apb(icc_pkg::ADDR_CTRL, 1, 32'h0);
    apb(icc_pkg::ADDR_STAT, 1, 32'h2);
    apb(icc_pkg::ADDR_STAT, 0, 32'h0);
    chk(n_start, 2);
    chk(q[1], 1'b0);
    apb(8'h40, 0, 32'h0);
    chk(perr, 1'b1);
    chk(q, 32'h00000000);
    $display("end master");
  endtask
  initial
  begin
    {psel, penable, pwrite, addr_rcvd, xfer_done, xfer_dir_tx} = 6'h00;
    {other_flag_set, ack_rcvd, ack_val, dtc_access} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    addr_byte = 7'h00;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    apb(icc_pkg::ADDR_STAT, 0, 32'h0);
    chk(q[2:0], 3'h1);
    t_slave();
    t_clk();
    t_master();
    complete_run();
  end
endmodule
bind icc_irq_ctrl icc_irq_ctrl_checker u_chk
(
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .addr_rcvd(addr_rcvd), .addr_byte(addr_byte),
  .xfer_done(xfer_done), .other_flag_set(other_flag_set), .ack_rcvd(ack_rcvd),
  .ack_val(ack_val), .dtc_access(dtc_access), .start_req(start_req), .stop_req(stop_req),
  .interrupt_request_flag(interrupt_request_flag)
);
`default_nettype wire
